// *** src/adc_route_map.svh ***
// Register offsets, field positions, reset values and decode constants
// Assumes inclusion by the input-route register bank and its level decoder
`ifndef ADC_ROUTE_MAP_SVH
`define ADC_ROUTE_MAP_SVH

`define L2R_ROUTE_OFS 8'h17
`define L1L_ROUTE_OFS 8'h18
`define MIC_CFG_OFS 8'h19

`define DIFF_BIT 7
`define LEVEL_HI 6
`define LEVEL_LO 3
`define CM_BIAS_BIT 2
`define BIAS_HI 7
`define BIAS_LO 6
`define DMIC_HI 5
`define DMIC_LO 4

`define DIFF_RST 1'b0
`define LEVEL_RST 4'hF
`define CM_BIAS_RST 1'b0
`define BIAS_RST 2'h0
`define DMIC_RST 2'h0
`define RDATA_RST 8'h00

`define LEVEL_MAX_CODE 4'h8
`define LEVEL_OFF_CODE 4'hF
`define STEP_HALF_DB 5'h03

`endif

// *** src/adc_route_pkg.sv ***
// Types shared by the input-route register bank
// Assumes nothing beyond a SystemVerilog compiler
package adc_route_pkg;

  typedef enum logic [1:0] {
    bias_off,
    bias_2v0,
    bias_2v5,
    bias_supply
  } mic_bias_level_t;

  typedef enum logic [1:0] {
    dmic_both,
    dmic_left_only,
    dmic_right_only,
    dmic_reserved
  } dmic_sel_t;

endpackage

// *** src/level_decode.sv ***
// Registered decoder of one four-bit input level code
// Assumes the code comes from a register on the same clock
`timescale 1ns/10ps
`include "adc_route_map.svh"

module level_decode #(
  parameter int CODE_W = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [CODE_W-1:0] code,
  output logic connect_ff,
  output logic [4:0] atten_ff,
  output logic reserved_ff
);

  logic nxt_connect;
  logic [4:0] nxt_atten;
  logic nxt_reserved;

  always_comb begin
    nxt_connect = (code <= `LEVEL_MAX_CODE);
    nxt_reserved = !nxt_connect && (code != `LEVEL_OFF_CODE);
    nxt_atten = 5'h00;
    if (nxt_connect) begin
      nxt_atten = 5'(code) * `STEP_HALF_DB;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      connect_ff <= 1'b0;
      atten_ff <= 5'h00;
      reserved_ff <= 1'b0;
    end else begin
      connect_ff <= nxt_connect;
      atten_ff <= nxt_atten;
      reserved_ff <= nxt_reserved;
    end
  end

  property p_atten_step;
    @(posedge ref_clk) disable iff (rst)
    ($past(code) <= `LEVEL_MAX_CODE) |-> (atten_ff == 5'($past(code)) * `STEP_HALF_DB);
  endproperty
  a_atten_step: assert property (p_atten_step) else $error("level attenuation step wrong");

  property p_off_code;
    @(posedge ref_clk) disable iff (rst)
    (code == `LEVEL_OFF_CODE) |=> (!connect_ff && !reserved_ff && atten_ff == 5'h00);
  endproperty
  a_off_code: assert property (p_off_code) else $error("off code did not disconnect");

endmodule

// *** src/adc_route_regs.sv ***
// Input-route, common-mode bias and microphone bias register bank
// Assumes a control-port front end on ref_clk delivering byte reads and writes
`timescale 1ns/10ps
`include "adc_route_map.svh"

module adc_route_regs (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_ff,
  output logic reg_rvalid_ff,
  output logic right_line_input_two_diff_ff,
  output logic right_line_input_two_connect_ff,
  output logic [4:0] right_line_input_two_atten_ff,
  output logic right_line_input_two_rsvd_code_ff,
  output logic left_line_input_one_diff_ff,
  output logic left_line_input_one_connect_ff,
  output logic [4:0] left_line_input_one_atten_ff,
  output logic left_line_input_one_rsvd_code_ff,
  output logic common_mode_bias_ff,
  output adc_route_pkg::mic_bias_level_t microphone_bias_output_ff,
  output adc_route_pkg::dmic_sel_t dmic_sel_ff
);
  import adc_route_pkg::*;

  logic [3:0] l2_level_ff;
  logic [3:0] l1_level_ff;
  logic nxt_l2_diff;
  logic [3:0] nxt_l2_level;
  logic nxt_cm_bias;
  logic nxt_l1_diff;
  logic [3:0] nxt_l1_level;
  mic_bias_level_t nxt_bias;
  dmic_sel_t nxt_dmic;
  logic [7:0] nxt_rdata;
  logic nxt_rvalid;
  logic wr_l2;
  logic wr_l1;
  logic wr_mic;

  assign wr_l2 = reg_wr && (reg_addr == `L2R_ROUTE_OFS);
  assign wr_l1 = reg_wr && (reg_addr == `L1L_ROUTE_OFS);
  assign wr_mic = reg_wr && (reg_addr == `MIC_CFG_OFS);

  // Write side
  always_comb begin
    nxt_l2_diff = right_line_input_two_diff_ff;
    nxt_l2_level = l2_level_ff;
    nxt_cm_bias = common_mode_bias_ff;
    nxt_l1_diff = left_line_input_one_diff_ff;
    nxt_l1_level = l1_level_ff;
    nxt_bias = microphone_bias_output_ff;
    nxt_dmic = dmic_sel_ff;
    if (wr_l2) begin
      nxt_l2_diff = reg_wdata[`DIFF_BIT];
      nxt_l2_level = reg_wdata[`LEVEL_HI:`LEVEL_LO];
      nxt_cm_bias = reg_wdata[`CM_BIAS_BIT];
    end
    if (wr_l1) begin
      nxt_l1_diff = reg_wdata[`DIFF_BIT];
      nxt_l1_level = reg_wdata[`LEVEL_HI:`LEVEL_LO];
    end
    if (wr_mic) begin
      nxt_bias = mic_bias_level_t'(reg_wdata[`BIAS_HI:`BIAS_LO]);
      nxt_dmic = dmic_sel_t'(reg_wdata[`DMIC_HI:`DMIC_LO]);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      right_line_input_two_diff_ff <= `DIFF_RST;
      l2_level_ff <= `LEVEL_RST;
      common_mode_bias_ff <= `CM_BIAS_RST;
      left_line_input_one_diff_ff <= `DIFF_RST;
      l1_level_ff <= `LEVEL_RST;
      microphone_bias_output_ff <= mic_bias_level_t'(`BIAS_RST);
      dmic_sel_ff <= dmic_sel_t'(`DMIC_RST);
    end else begin
      right_line_input_two_diff_ff <= nxt_l2_diff;
      l2_level_ff <= nxt_l2_level;
      common_mode_bias_ff <= nxt_cm_bias;
      left_line_input_one_diff_ff <= nxt_l1_diff;
      l1_level_ff <= nxt_l1_level;
      microphone_bias_output_ff <= nxt_bias;
      dmic_sel_ff <= nxt_dmic;
    end
  end

  // Read side; reserved bits are constant zero
  always_comb begin
    nxt_rvalid = reg_rd;
    nxt_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `L2R_ROUTE_OFS: begin
          nxt_rdata = {right_line_input_two_diff_ff, l2_level_ff, common_mode_bias_ff,
                       2'h0};
        end
        `L1L_ROUTE_OFS: begin
          nxt_rdata = {left_line_input_one_diff_ff, l1_level_ff, 3'h0};
        end
        `MIC_CFG_OFS: begin
          nxt_rdata = {microphone_bias_output_ff, dmic_sel_ff, 4'h0};
        end
        default: begin
          nxt_rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_ff <= `RDATA_RST;
      reg_rvalid_ff <= 1'b0;
    end else begin
      reg_rdata_ff <= nxt_rdata;
      reg_rvalid_ff <= nxt_rvalid;
    end
  end

  // Level decoders drive the mixer switches and attenuators
  level_decode #(.CODE_W(4)) u_l2_dec (
    .ref_clk(ref_clk),
    .rst(rst),
    .code(l2_level_ff),
    .connect_ff(right_line_input_two_connect_ff),
    .atten_ff(right_line_input_two_atten_ff),
    .reserved_ff(right_line_input_two_rsvd_code_ff)
  );

  level_decode #(.CODE_W(4)) u_l1_dec (
    .ref_clk(ref_clk),
    .rst(rst),
    .code(l1_level_ff),
    .connect_ff(left_line_input_one_connect_ff),
    .atten_ff(left_line_input_one_atten_ff),
    .reserved_ff(left_line_input_one_rsvd_code_ff)
  );

  // Checks
  sequence s_wr_l2_valid;
    wr_l2 && (reg_wdata[`LEVEL_HI:`LEVEL_LO] <= `LEVEL_MAX_CODE);
  endsequence

  sequence s_wr_l1_valid;
    wr_l1 && (reg_wdata[`LEVEL_HI:`LEVEL_LO] <= `LEVEL_MAX_CODE);
  endsequence

  sequence s_no_write_between;
    !wr_l2 [*2];
  endsequence

  sequence s_wr_l2_off;
    wr_l2 && (reg_wdata[`LEVEL_HI:`LEVEL_LO] == `LEVEL_OFF_CODE);
  endsequence

  sequence s_wr_l1_off;
    wr_l1 && (reg_wdata[`LEVEL_HI:`LEVEL_LO] == `LEVEL_OFF_CODE);
  endsequence

  property p_l2_diff;
    @(posedge ref_clk) disable iff (rst)
    wr_l2 |=> (right_line_input_two_diff_ff == $past(reg_wdata[7]));
  endproperty
  a_l2_diff: assert property (p_l2_diff) else $error("line two mode not stored");

  property p_l2_connect;
    @(posedge ref_clk) disable iff (rst)
    s_wr_l2_valid ##1 !wr_l2 |=> right_line_input_two_connect_ff;
  endproperty
  a_l2_connect: assert property (p_l2_connect) else $error("line two not connected");

  property p_l2_disconnect;
    @(posedge ref_clk) disable iff (rst)
    s_wr_l2_off ##1 !wr_l2 |=> !right_line_input_two_connect_ff;
  endproperty
  a_l2_disconnect: assert property (p_l2_disconnect) else $error("line two not cut");

  property p_cm_bias;
    @(posedge ref_clk) disable iff (rst)
    wr_l2 ##1 s_no_write_between |-> (common_mode_bias_ff == $past(reg_wdata[`CM_BIAS_BIT], 2));
  endproperty
  a_cm_bias: assert property (p_cm_bias) else $error("bias control not held");

  property p_l1_diff;
    @(posedge ref_clk) disable iff (rst)
    wr_l1 |=> (left_line_input_one_diff_ff == $past(reg_wdata[7]));
  endproperty
  a_l1_diff: assert property (p_l1_diff) else $error("line one mode not stored");

  property p_l1_connect;
    @(posedge ref_clk) disable iff (rst)
    s_wr_l1_valid ##1 !wr_l1 |=> left_line_input_one_connect_ff;
  endproperty
  a_l1_connect: assert property (p_l1_connect) else $error("line one not connected");

  property p_rsvd_route;
    @(posedge ref_clk) disable iff (rst)
    (reg_rd && reg_addr == `L2R_ROUTE_OFS) |=> (reg_rvalid_ff && reg_rdata_ff[1:0] == 2'h0);
  endproperty
  a_rsvd_route: assert property (p_rsvd_route) else $error("reserved route bits set");

  property p_rsvd_route1;
    @(posedge ref_clk) disable iff (rst)
    (reg_rd && reg_addr == `L1L_ROUTE_OFS) |=> (reg_rdata_ff[2:0] == 3'h0);
  endproperty
  a_rsvd_route1: assert property (p_rsvd_route1) else $error("reserved line one bits set");

  property p_bias_level;
    @(posedge ref_clk) disable iff (rst)
    wr_mic |=> (microphone_bias_output_ff == mic_bias_level_t'($past(reg_wdata[7:6])));
  endproperty
  a_bias_level: assert property (p_bias_level) else $error("bias level not stored");

  property p_dmic_sel;
    @(posedge ref_clk) disable iff (rst)
    wr_mic |=> (dmic_sel_ff == dmic_sel_t'($past(reg_wdata[5:4])));
  endproperty
  a_dmic_sel: assert property (p_dmic_sel) else $error("mic select not stored");

  property p_rsvd_mic;
    @(posedge ref_clk) disable iff (rst)
    (reg_rd && reg_addr == `MIC_CFG_OFS) |=> (reg_rdata_ff[3:0] == 4'h0);
  endproperty
  a_rsvd_mic: assert property (p_rsvd_mic) else $error("reserved bias bits set");

  property p_other_addr;
    @(posedge ref_clk) disable iff (rst)
    (reg_wr && !wr_l2 && !wr_l1 && !wr_mic) |=>
      ($stable(l2_level_ff) && $stable(l1_level_ff) && $stable(microphone_bias_output_ff));
  endproperty
  a_other_addr: assert property (p_other_addr) else $error("foreign write changed a field");

  property p_l1_disconnect;
    @(posedge ref_clk) disable iff (rst)
    s_wr_l1_off ##1 !wr_l1 |=>
      (!left_line_input_one_connect_ff && left_line_input_one_atten_ff == 5'h00);
  endproperty
  a_l1_disconnect: assert property (p_l1_disconnect) else $error("line one not cut");

  property p_l2_level_stored;
    @(posedge ref_clk) disable iff (rst)
    wr_l2 |=> (l2_level_ff == $past(reg_wdata[`LEVEL_HI:`LEVEL_LO]));
  endproperty
  a_l2_level_stored: assert property (p_l2_level_stored) else $error("line two level lost");

  property p_l2_mode_held;
    @(posedge ref_clk) disable iff (rst)
    !wr_l2 |=> ($stable(right_line_input_two_diff_ff) && $stable(common_mode_bias_ff));
  endproperty
  a_l2_mode_held: assert property (p_l2_mode_held) else $error("line two mode drifted");

  property p_rd_answer;
    @(posedge ref_clk) disable iff (rst)
    reg_rd |=> reg_rvalid_ff;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");

  property p_idle_rdata;
    @(posedge ref_clk) disable iff (rst)
    !reg_rd |=> (!reg_rvalid_ff && reg_rdata_ff == `RDATA_RST);
  endproperty
  a_idle_rdata: assert property (p_idle_rdata) else $error("read data without read");

  property p_l2_readback;
    @(posedge ref_clk) disable iff (rst)
    (reg_rd && reg_addr == `L2R_ROUTE_OFS) |=>
      (reg_rdata_ff[`DIFF_BIT:`CM_BIAS_BIT] ==
       $past({right_line_input_two_diff_ff, l2_level_ff, common_mode_bias_ff}));
  endproperty
  a_l2_readback: assert property (p_l2_readback) else $error("line two readback wrong");

  property p_mic_readback;
    @(posedge ref_clk) disable iff (rst)
    (reg_rd && reg_addr == `MIC_CFG_OFS) |=>
      (reg_rdata_ff[`BIAS_HI:`DMIC_LO] == $past({microphone_bias_output_ff, dmic_sel_ff}));
  endproperty
  a_mic_readback: assert property (p_mic_readback) else $error("mic readback wrong");

  property p_l1_keeps_l2;
    @(posedge ref_clk) disable iff (rst)
    wr_l1 |=> ($stable(l2_level_ff) && $stable(right_line_input_two_diff_ff) &&
               $stable(common_mode_bias_ff));
  endproperty
  a_l1_keeps_l2: assert property (p_l1_keeps_l2) else $error("line one write hit line two");

  property p_mic_keeps_route;
    @(posedge ref_clk) disable iff (rst)
    wr_mic |=> ($stable(l1_level_ff) && $stable(l2_level_ff) &&
                $stable(left_line_input_one_diff_ff));
  endproperty
  a_mic_keeps_route: assert property (p_mic_keeps_route) else $error("mic write hit route");

  property p_unmapped_rd;
    @(posedge ref_clk) disable iff (rst)
    (reg_rd && !(reg_addr inside {`L2R_ROUTE_OFS, `L1L_ROUTE_OFS, `MIC_CFG_OFS})) |=>
      (reg_rvalid_ff && reg_rdata_ff == 8'h00);
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");

endmodule

// *** verif/host_model.sv ***
// Host side of the register port: byte write and byte read tasks
// Assumes the bank takes its strobes on the rising edge of ref_clk
`timescale 1ns/10ps

module host_model (
  input wire logic ref_clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata_ff,
  input wire logic reg_rvalid_ff
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  // Idle address and data show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  // Answer is looked at in the one cycle that it stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata_ff;
    v = reg_rvalid_ff;
  endtask
endmodule

// *** verif/adc_route_regs_test.sv ***
// Self-checking bench for the input-route register bank
// Assumes host_model drives the register port
`timescale 1ns/10ps
`include "adc_route_map.svh"

module adc_route_regs_test;
  import adc_route_pkg::*;
  logic ref_clk;
  logic rst;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic [7:0] reg_wdata;
  logic reg_rd;
  logic [7:0] reg_rdata_ff;
  logic reg_rvalid_ff;
  logic l2_diff, l2_conn, l2_rsvd, l1_diff, l1_conn, l1_rsvd, cm_bias;
  logic [4:0] l2_att;
  logic [4:0] l1_att;
  mic_bias_level_t bias;
  dmic_sel_t dsel;
  logic [3:0] code;
  int err_total = 0;
  int check_count = 0;

  adc_route_regs adc_route_regs_i (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .reg_rvalid_ff(reg_rvalid_ff), .right_line_input_two_diff_ff(l2_diff),
    .right_line_input_two_connect_ff(l2_conn), .right_line_input_two_atten_ff(l2_att),
    .right_line_input_two_rsvd_code_ff(l2_rsvd), .left_line_input_one_diff_ff(l1_diff),
    .left_line_input_one_connect_ff(l1_conn), .left_line_input_one_atten_ff(l1_att),
    .left_line_input_one_rsvd_code_ff(l1_rsvd), .common_mode_bias_ff(cm_bias),
    .microphone_bias_output_ff(bias), .dmic_sel_ff(dsel)
  );

  host_model host_model_i (
    .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic rd_cmp(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    logic v;
    host_model_i.rd(a, d, v);
    cmp({7'h0, v}, 8'h01, "read valid");
    cmp(d, exp, what);
  endtask

  task automatic end_sim();
    $display("Checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    err_total++;
    $display("BAD %0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    rst = 1'b1;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    rd_cmp(`L2R_ROUTE_OFS, 8'h78, "line two reset");
    rd_cmp(`L1L_ROUTE_OFS, 8'h78, "line one reset");
    rd_cmp(`MIC_CFG_OFS, 8'h00, "mic reset");
    cmp({6'h0, l2_conn, l1_conn}, 8'h00, "inputs off");
    $display("Test reset done");
    // Each input feeds one channel only, reserved codes skipped
    for (int c = 0; c < 10; c++) begin
      code = (c == 9) ? 4'hF : 4'(c);
      host_model_i.wr(`L2R_ROUTE_OFS, {c[0], code, c[1], 2'b11});
      host_model_i.wr(`L1L_ROUTE_OFS, {c[0], code, 3'b111});
      rd_cmp(`L2R_ROUTE_OFS, {c[0], code, c[1], 2'b00}, "line two route");
      rd_cmp(`L1L_ROUTE_OFS, {c[0], code, 3'b000}, "line one route");
      cmp({7'h0, l2_conn}, {7'h0, c < 9}, "line two connect");
      cmp({7'h0, l1_conn}, {7'h0, c < 9}, "line one connect");
      cmp({3'h0, l2_att}, (c < 9) ? 8'(c * 3) : 8'h00, "line two atten");
      cmp({3'h0, l1_att}, (c < 9) ? 8'(c * 3) : 8'h00, "line one atten");
      cmp({5'h0, l2_diff, cm_bias, l2_rsvd}, {5'h0, c[0], c[1], 1'b0}, "line two mode");
      cmp({6'h0, l1_diff, l1_rsvd}, {6'h0, c[0], 1'b0}, "line one mode");
    end
    $display("Test route done");
    // Reserved select code never written
    for (int b = 0; b < 4; b++) begin
      for (int s = 0; s < 3; s++) begin
        host_model_i.wr(`MIC_CFG_OFS, {b[1:0], s[1:0], 4'hF});
        rd_cmp(`MIC_CFG_OFS, {b[1:0], s[1:0], 4'h0}, "mic cfg");
        cmp({6'h0, bias}, 8'(b), "bias level");
        cmp({6'h0, dsel}, 8'(s), "dmic select");
      end
    end
    $display("Test mic done");
    host_model_i.wr(8'h1A, 8'h00);
    rd_cmp(8'h1A, 8'h00, "unmapped");
    rd_cmp(`L2R_ROUTE_OFS, 8'hF8, "line two kept");
    rd_cmp(`MIC_CFG_OFS, 8'hE0, "mic kept");
    @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    rd_cmp(`L2R_ROUTE_OFS, 8'h78, "line two second reset");
    rd_cmp(`MIC_CFG_OFS, 8'h00, "mic second reset");
    $display("Test unmapped and reset done");
    end_sim();
  end
endmodule
